// ===== hdl/lbp_defines.svh
`ifndef LBP_DEFINES_SVH
`define LBP_DEFINES_SVH

// ==========================================
// Clock and timing
`define LBP_CLK_FREQ_HZ 50000000
`define LBP_PWM_FREQ_HZ 5000
`define LBP_TICK_TIME_US 25000
`define LBP_US_PER_S 1000000

// ==========================================
// Management register indices (byte address = index * 4)
`define LBP_IDX_MODE_SELECT 5'h1d
`define LBP_IDX_BEHAVIOR 5'h1e
`define LBP_IDX_PAGE_SELECT 5'h1f
`define LBP_IDX_EXT_FIRST 5'h10
`define LBP_ADDR_DUTY 8'h80
`define LBP_ADDR_MGMT_TOP 8'h7f

// ==========================================
// Behaviour register layout
`define LBP_BEH_PULSE_BIT 12
`define LBP_BEH_RATE_HI 11
`define LBP_BEH_RATE_LO 10
`define LBP_BEH_SEL_HI 8
`define LBP_BEH_SEL_LO 5
`define LBP_BEH_COMB_HI 3
`define LBP_BEH_COMB_LO 0
`define LBP_BEH_MASK 16'h1de_f

// ==========================================
// Reset values and page codes
`define LBP_RATE_RST 2'h1
`define LBP_MODE_RST 16'h8021
`define LBP_PAGE_RST 16'h0000
`define LBP_PAGE_EXT1 16'h0001
`define LBP_PAGE_EXT2 16'h0002
`define LBP_PAGE_EXT3 16'h0003
`define LBP_PAGE_GPIO 16'h0010
`define LBP_DUTY_RST 14'h1388

// ==========================================
// Blink and stretch lengths in ticks
`define LBP_BLINK_HALF_SLOW 4'h8
`define LBP_STRETCH_SLOW 5'h10

`endif

// ===== hdl/lbp_pkg.sv
package lbp_pkg;

  // ==========================================
  // Register space that an access reaches
  typedef enum logic [2:0] {
    LBP_SPC_MAIN = 3'h0,
    LBP_SPC_EXT1 = 3'h1,
    LBP_SPC_EXT2 = 3'h2,
    LBP_SPC_EXT3 = 3'h3,
    LBP_SPC_GPIO = 3'h4
  } lbp_space_e;

  // ==========================================
  // Bus slave states
  typedef enum logic [1:0] {
    LBP_ST_IDLE = 2'h0,
    LBP_ST_WR = 2'h1,
    LBP_ST_RD = 2'h2
  } lbp_state_e;

endpackage : lbp_pkg

// ===== hdl/lbp_top.sv
// Summary of operation
// - Behaviour settings readable and writable at 30
// - Pulsing bit gates active outputs at 5 kHz
// - Rate field picks blink and stretch length
// - Rate field resets to 5 Hz, 200 ms
// - Only port zero rate field is used
// - Combine-disable bit shows base function only
// - Page select at 31 resets to main
// - Pages 1 to 3 route 16-30 to extended
// - Page 0x10 routes 0-30 to GPIO
// - Registers 0-15 stay standard on extended pages
// - Register 29 holds four 4-bit mode codes
`timescale 1ns/1ps
`include "lbp_defines.svh"

module lbp_top #(
  parameter int unsigned TICK_CYCLES = `LBP_TICK_TIME_US * (`LBP_CLK_FREQ_HZ / `LBP_US_PER_S),
  parameter int unsigned PWM_CYCLES = `LBP_CLK_FREQ_HZ / `LBP_PWM_FREQ_HZ
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Port identity and shared rate
  input wire logic is_port_zero,
  input wire logic [1:0] port_zero_rate,
  output logic [1:0] rate_out,
  // Indicator functions chosen by mode codes
  input wire logic [3:0] base_state,
  input wire logic [3:0] event_state,
  output logic [15:0] mode_select,
  // Routing of accesses held elsewhere
  output logic route_strobe,
  output logic route_write,
  output logic [2:0] route_space,
  output logic [4:0] route_reg,
  output logic [15:0] route_wdata,
  // Indicator pins
  output logic indicator_out_0,
  output logic indicator_out_1,
  output logic indicator_out_2,
  output logic indicator_out_3
);

  // ==========================================
  // Registers
  logic pulse_en;
  logic [1:0] rate;
  logic [3:0] stretch_sel;
  logic [3:0] comb_dis;
  logic [15:0] page;
  logic [13:0] duty;
  logic [15:0] beh_rd;

  // ==========================================
  // Bus slave
  lbp_pkg::lbp_state_e state;
  lbp_pkg::lbp_state_e next_state;
  logic [7:0] addr_q;
  logic take;
  logic is_mgmt;
  logic [4:0] idx;
  lbp_pkg::lbp_space_e space;
  logic local_reg;
  logic [15:0] rd_mux;

  assign take = hsel && htrans[1] && hready;
  assign is_mgmt = addr_q <= `LBP_ADDR_MGMT_TOP;
  assign idx = addr_q[6:2];

  // reserved zero
  // Bit 4 is the only reserved bit below the select field
  assign beh_rd = {3'h0, pulse_en, rate, 1'b0, stretch_sel, 1'b0, comb_dis};

  always_comb begin
    space = lbp_pkg::LBP_SPC_MAIN;
    if (idx != `LBP_IDX_PAGE_SELECT) begin
      if (page == `LBP_PAGE_GPIO) begin
        space = lbp_pkg::LBP_SPC_GPIO;
      end else if (idx >= `LBP_IDX_EXT_FIRST) begin
        if (page == `LBP_PAGE_EXT1) begin
          space = lbp_pkg::LBP_SPC_EXT1;
        end else if (page == `LBP_PAGE_EXT2) begin
          space = lbp_pkg::LBP_SPC_EXT2;
        end else if (page == `LBP_PAGE_EXT3) begin
          space = lbp_pkg::LBP_SPC_EXT3;
        end
      end
    end
  end

  assign local_reg = (space == lbp_pkg::LBP_SPC_MAIN) && (idx == `LBP_IDX_MODE_SELECT ||
    idx == `LBP_IDX_BEHAVIOR || idx == `LBP_IDX_PAGE_SELECT);

  always_comb begin
    rd_mux = 16'h0000;
    if (addr_q == `LBP_ADDR_DUTY) begin
      rd_mux = {2'h0, duty};
    end else if (is_mgmt && local_reg) begin
      unique case (idx)
        `LBP_IDX_MODE_SELECT: rd_mux = mode_select;
        `LBP_IDX_BEHAVIOR: rd_mux = beh_rd;
        default: rd_mux = page;
      endcase
    end
  end

  always_comb begin
    next_state = lbp_pkg::LBP_ST_IDLE;
    unique case (state)
      lbp_pkg::LBP_ST_IDLE, lbp_pkg::LBP_ST_WR: begin
        if (take) begin
          next_state = hwrite ? lbp_pkg::LBP_ST_WR : lbp_pkg::LBP_ST_RD;
        end
      end
      lbp_pkg::LBP_ST_RD: next_state = lbp_pkg::LBP_ST_IDLE;
      default: next_state = lbp_pkg::LBP_ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= lbp_pkg::LBP_ST_IDLE;
      addr_q <= 8'h00;
    end else begin
      state <= next_state;
      if (take) begin
        addr_q <= (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hff;
      end
    end
  end

  // Reads take one wait state so data is fresh after a write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      hresp <= 1'b0;
      if (take && !hwrite) begin
        hreadyout <= 1'b0;
      end else if (state == lbp_pkg::LBP_ST_RD) begin
        hreadyout <= 1'b1;
        hrdata <= {16'h0000, rd_mux};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_en <= 1'b0;
      rate <= `LBP_RATE_RST;
      stretch_sel <= 4'h0;
      comb_dis <= 4'h0;
      mode_select <= `LBP_MODE_RST;
      page <= `LBP_PAGE_RST;
      duty <= `LBP_DUTY_RST;
    end else if (state == lbp_pkg::LBP_ST_WR) begin
      if (addr_q == `LBP_ADDR_DUTY) begin
        duty <= hwdata[13:0];
      end else if (is_mgmt && local_reg) begin
        unique case (idx)
          `LBP_IDX_MODE_SELECT: mode_select <= hwdata[15:0];
          `LBP_IDX_BEHAVIOR: begin
            pulse_en <= hwdata[`LBP_BEH_PULSE_BIT];
            rate <= hwdata[`LBP_BEH_RATE_HI:`LBP_BEH_RATE_LO];
            stretch_sel <= hwdata[`LBP_BEH_SEL_HI:`LBP_BEH_SEL_LO];
            comb_dis <= hwdata[`LBP_BEH_COMB_HI:`LBP_BEH_COMB_LO];
          end
          default: page <= hwdata[15:0];
        endcase
      end
    end
  end

  // Accesses to registers held outside this block
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      route_strobe <= 1'b0;
      route_write <= 1'b0;
      route_space <= 3'h0;
      route_reg <= 5'h00;
      route_wdata <= 16'h0000;
    end else begin
      route_strobe <= 1'b0;
      if ((state == lbp_pkg::LBP_ST_WR || state == lbp_pkg::LBP_ST_RD) && is_mgmt && !local_reg) begin
        route_strobe <= 1'b1;
        route_write <= state == lbp_pkg::LBP_ST_WR;
        route_space <= space;
        route_reg <= idx;
        route_wdata <= hwdata[15:0];
      end
    end
  end

  // ==========================================
  // Timebase
  logic [1:0] eff_rate;
  logic [23:0] tick_cnt;
  logic tick;
  logic [13:0] pwm_cnt;
  logic pwm_hi;
  logic [3:0] blink_cnt;
  logic [3:0] blink_half;
  logic blink_phase;
  logic [4:0] stretch_load;

  assign eff_rate = is_port_zero ? rate : port_zero_rate;
  assign blink_half = `LBP_BLINK_HALF_SLOW >> eff_rate;
  // One extra tick so a mid-tick event still gets the full time
  assign stretch_load = 5'((`LBP_STRETCH_SLOW >> eff_rate) + 5'h01);
  assign tick = tick_cnt == 24'(TICK_CYCLES - 1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_out <= `LBP_RATE_RST;
    end else begin
      rate_out <= rate;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt <= 24'h00_0000;
    end else begin
      tick_cnt <= tick ? 24'h00_0000 : 24'(tick_cnt + 24'h00_0001);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blink_cnt <= 4'h0;
      blink_phase <= 1'b0;
    end else if (tick) begin
      if (blink_cnt >= 4'(blink_half - 4'h1)) begin
        blink_cnt <= 4'h0;
        blink_phase <= !blink_phase;
      end else begin
        blink_cnt <= 4'(blink_cnt + 4'h1);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwm_cnt <= 14'h0000;
    end else if (pwm_cnt == 14'(PWM_CYCLES - 1)) begin
      pwm_cnt <= 14'h0000;
    end else begin
      pwm_cnt <= 14'(pwm_cnt + 14'h0001);
    end
  end

  assign pwm_hi = pwm_cnt < duty;

  // ==========================================
  // Indicator outputs
  logic [3:0] led_q;
  logic [3:0] lit;
  logic [4:0] stretch_cnt [4];

  for (genvar g = 0; g < 4; g++) begin : g_led
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        stretch_cnt[g] <= 5'h00;
      end else if (event_state[g]) begin
        stretch_cnt[g] <= stretch_load;
      end else if (tick && stretch_cnt[g] != 5'h00) begin
        stretch_cnt[g] <= 5'(stretch_cnt[g] - 5'h01);
      end
    end

    always_comb begin
      lit[g] = base_state[g];
      if (!comb_dis[g]) begin
        if (stretch_sel[g]) begin
          lit[g] = base_state[g] || stretch_cnt[g] != 5'h00;
        end else if (event_state[g]) begin
          lit[g] = blink_phase;
        end
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        led_q[g] <= 1'b0;
      end else begin
        led_q[g] <= lit[g] && (!pulse_en || pwm_hi);
      end
    end
  end

  assign indicator_out_0 = led_q[0];
  assign indicator_out_1 = led_q[1];
  assign indicator_out_2 = led_q[2];
  assign indicator_out_3 = led_q[3];

  // ==========================================
  // Assertions
  property p_beh_write;
    @(posedge hclk) disable iff (!hresetn)
      (state == lbp_pkg::LBP_ST_WR && is_mgmt && idx == `LBP_IDX_BEHAVIOR && space == lbp_pkg::LBP_SPC_MAIN)
      |=> beh_rd == ($past(hwdata[15:0]) & `LBP_BEH_MASK);
  endproperty
  a_beh_write: assert property (p_beh_write) else $error("behaviour write not stored");

  property p_reserved;
    @(posedge hclk) disable iff (!hresetn)
      (state == lbp_pkg::LBP_ST_RD && idx == `LBP_IDX_BEHAVIOR && local_reg)
      |=> (hrdata[15:0] & ~`LBP_BEH_MASK) == 16'h0000 && hreadyout;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  property p_pulse_off;
    @(posedge hclk) disable iff (!hresetn)
      !pulse_en |=> led_q == $past(lit);
  endproperty
  a_pulse_off: assert property (p_pulse_off) else $error("output gated without pulsing");

  property p_pwm_wrap;
    @(posedge hclk) disable iff (!hresetn)
      pwm_cnt == 14'(PWM_CYCLES - 1) |=> pwm_cnt == 14'h0000 ##1 pwm_cnt == 14'h0001;
  endproperty
  a_pwm_wrap: assert property (p_pwm_wrap) else $error("pulse period wrong");

  property p_rate_src;
    @(posedge hclk) disable iff (!hresetn)
      !is_port_zero |-> eff_rate == port_zero_rate;
  endproperty
  a_rate_src: assert property (p_rate_src) else $error("rate not taken from port zero");

  property p_low_regs;
    @(posedge hclk) disable iff (!hresetn)
      (route_strobe && route_reg < `LBP_IDX_EXT_FIRST && $past(page) != `LBP_PAGE_GPIO)
      |-> route_space == lbp_pkg::LBP_SPC_MAIN;
  endproperty
  a_low_regs: assert property (p_low_regs) else $error("low register left main space");

  property p_gpio;
    @(posedge hclk) disable iff (!hresetn)
      (route_strobe && $past(page) == `LBP_PAGE_GPIO) |-> route_space == lbp_pkg::LBP_SPC_GPIO;
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio page not routed");

  property p_ext;
    @(posedge hclk) disable iff (!hresetn)
      (route_strobe && route_reg >= `LBP_IDX_EXT_FIRST && $past(page) == `LBP_PAGE_EXT2)
      |-> route_space == lbp_pkg::LBP_SPC_EXT2;
  endproperty
  a_ext: assert property (p_ext) else $error("extended page not routed");

  property p_stretch;
    @(posedge hclk) disable iff (!hresetn)
      event_state[0] |=> stretch_cnt[0] == $past(stretch_load) && stretch_cnt[0] != 5'h00;
  endproperty
  a_stretch: assert property (p_stretch) else $error("stretch not restarted");

  property p_mode;
    @(posedge hclk) disable iff (!hresetn)
      (state == lbp_pkg::LBP_ST_WR && is_mgmt && idx == `LBP_IDX_MODE_SELECT && space == lbp_pkg::LBP_SPC_MAIN)
      |=> mode_select == $past(hwdata[15:0]);
  endproperty
  a_mode: assert property (p_mode) else $error("mode codes not stored");

  c_read: cover property (@(posedge hclk) disable iff (!hresetn) state == lbp_pkg::LBP_ST_RD ##1 hreadyout);
  c_route: cover property (@(posedge hclk) disable iff (!hresetn) route_strobe && route_space != 3'h0);
  c_pulse: cover property (@(posedge hclk) disable iff (!hresetn) pulse_en && $fell(led_q[0]));
  c_blink: cover property (@(posedge hclk) disable iff (!hresetn) event_state[1] && $changed(blink_phase));

endmodule : lbp_top

// ===== verif/lbp_led_model.sv
`timescale 1ns/1ps
// ==========================================
// Indicator lamps on the far side
module lbp_led_model (
  // Clock and control
  input wire logic hclk,
  input wire logic clear,
  // Lamp pins, high = lit
  input wire logic [3:0] lamp,
  // Lit cycles since the last clear
  output logic [3:0][15:0] lit
);
  // Lamps only glow, so a duty measurement is a lit-cycle count
  always_ff @(posedge hclk) begin
    for (int i = 0; i < 4; i++) begin
      lit[i] <= clear ? 16'h0000 : lit[i] + {15'h0000, lamp[i]};
    end
  end
endmodule : lbp_led_model

// ===== verif/lbp_top_tb.sv
`timescale 1ns/1ps
module lbp_top_tb;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, is_port_zero, clr;
  logic route_strobe, route_write;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0] htrans, port_zero_rate, rate_out;
  logic [2:0] hsize, route_space;
  logic [3:0] base_state, event_state, lamp;
  logic [15:0] mode_select, route_wdata;
  logic [4:0] route_reg;
  logic [3:0][15:0] lit;
  logic [15:0] pg [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0010};
  logic [2:0] sp_hi [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
  logic [2:0] sp_lo [5] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h4};
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  assign hready = hreadyout;

  // Short tick and pwm period keep the run brief
  lbp_top #(.TICK_CYCLES(4), .PWM_CYCLES(20)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .is_port_zero(is_port_zero),
    .port_zero_rate(port_zero_rate), .rate_out(rate_out), .base_state(base_state),
    .event_state(event_state), .mode_select(mode_select), .route_strobe(route_strobe),
    .route_write(route_write), .route_space(route_space), .route_reg(route_reg),
    .route_wdata(route_wdata), .indicator_out_0(lamp[0]), .indicator_out_1(lamp[1]),
    .indicator_out_2(lamp[2]), .indicator_out_3(lamp[3]));
  lbp_led_model u_led (.hclk(hclk), .clear(clr), .lamp(lamp), .lit(lit));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  // ==========================================
  // Helpers
  task automatic end_sim();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask : bus

  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask : tick

  task automatic route(input logic [4:0] r, input logic [2:0] sp);
    bus(1'b1, {25'h0, r, 2'h0}, 32'h0000_5a5a);
    for (int k = 0; k < 4 && route_strobe !== 1'b1; k++) @(posedge hclk);
    chk("route_strobe", 32'h1, route_strobe);
    chk("route_space", sp, route_space);
    chk("route_reg", r, route_reg);
    chk("route_wdata", 32'h0001_5a5a, {route_write, route_wdata});
  endtask : route

  // Stretch on output 0 from one event, base held off
  task automatic stretch(input logic [1:0] rt, input int lit_at, input int dark_at);
    bus(1'b1, 32'h78, {20'h0, rt, 10'h020});
    event_state[0] <= 1'b1;
    @(posedge hclk);
    event_state[0] <= 1'b0;
    tick(lit_at);
    chk("stretch lit", 32'h1, lamp[0]);
    tick(dark_at - lit_at);
    chk("stretch dark", 32'h0, lamp[0]);
  endtask : stretch

  task automatic measure(input int n);
    clr <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
    tick(n);
  endtask : measure

  initial begin
    forever begin
      @(posedge hclk);
      cyc++;
      if (cyc > 20000) begin
        n_errors++;
        end_sim();
      end
    end
  end

  // ==========================================
  // Main sequence
  initial begin
    hresetn = 1'b0;
    {hsel, htrans, hwrite, haddr, hwdata} = '0;
    hsize = 3'h2;
    is_port_zero = 1'b1;
    port_zero_rate = 2'h0;
    base_state = 4'h0;
    event_state = 4'h0;
    clr = 1'b1;
    tick(3);
    hresetn <= 1'b1;
    clr <= 1'b0;
    bus(1'b0, 32'h78, 0);
    chk("behaviour", 32'h0400, q);
    bus(1'b0, 32'h7c, 0);
    chk("page", 32'h0, q);
    chk("hresp", 32'h0, hresp);
    chk("rate_out", 32'h1, rate_out);
    bus(1'b0, 32'h74, 0);
    chk("mode", 32'h8021, q);
    $display("Test reset values done");
    bus(1'b1, 32'h78, 32'hffff_ffff);
    bus(1'b0, 32'h78, 0);
    chk("behaviour", 32'h1def, q);
    chk("rate_out", 32'h3, rate_out);
    bus(1'b1, 32'h74, 32'h0000_1234);
    @(posedge hclk);
    chk("mode_select", 32'h1234, mode_select);
    bus(1'b0, 32'h100, 0);
    chk("unmapped", 32'h0, q);
    $display("Test register access done");
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, 32'h7c, {16'h0, pg[i]});
      bus(1'b0, 32'h7c, 0);
      chk("page", {16'h0, pg[i]}, q);
      route(5'd20, sp_hi[i]);
      route(5'd5, sp_lo[i]);
    end
    bus(1'b1, 32'h7c, 0);
    $display("Test page routing done");
    stretch(2'h3, 6, 16);
    stretch(2'h0, 62, 72);
    stretch(2'h1, 30, 40);
    event_state[0] <= 1'b1;
    @(posedge hclk);
    event_state[0] <= 1'b0;
    tick(30);
    chk("stretch restart", 32'h1, lamp[0]);
    is_port_zero <= 1'b0;
    port_zero_rate <= 2'h3;
    stretch(2'h0, 6, 16);
    is_port_zero <= 1'b1;
    $display("Test stretch done");
    bus(1'b1, 32'h78, 32'h0000_0421);
    event_state[0] <= 1'b1;
    tick(6);
    chk("combine off", 32'h0, lamp[0]);
    base_state[0] <= 1'b1;
    tick(3);
    chk("combine off base", 32'h1, lamp[0]);
    base_state[0] <= 1'b0;
    bus(1'b1, 32'h78, 32'h0000_0400);
    measure(160);
    chk("blink half", 32'h1, lit[0] >= 16'd64 && lit[0] <= 16'd96);
    event_state[0] <= 1'b0;
    base_state[0] <= 1'b1;
    bus(1'b1, 32'h80, 32'h0000_0005);
    bus(1'b1, 32'h78, 32'h0000_1001);
    measure(200);
    chk("pulse duty", 32'h1, lit[0] >= 16'd45 && lit[0] <= 16'd55);
    bus(1'b1, 32'h78, 32'h0000_0001);
    measure(100);
    chk("steady", 32'h1, lit[0] >= 16'd98);
    $display("Test indicators done");
    end_sim();
  end
endmodule : lbp_top_tb
